// ===== brsc_checker.sv
/* Checker for brsc_ctrl: timing relations at its ports.
   Assumes it is bound to the single brsc_ctrl instance. */
`timescale 1ns/10ps
// ========================================
// Checker
module brsc_checker (
  // Clock and reset
  input wire        mclk,
  input wire        reset_n,
  // Watched ports
  input wire        primary_reset_in_n,
  input wire        primary_system_error_oe,
  input wire        primary_grant_oe,
  input wire        primary_outputs_oe,
  input wire        secondary_reset_out_n,
  input wire        arbiter_select_n,
  input wire        int_arb_gnt0_n,
  input wire        bridge_bus_req,
  input wire        secondary_request_zero_n,
  input wire        secondary_grant_zero_n,
  input wire        ext_arb_granted,
  input wire        primary_66mhz_strap,
  input wire        bus_power_clock_ctl_pin,
  input wire        secondary_bus_b2,
  input wire [3:0]  gpio_oe,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  pri_tristate_a: assert property (!primary_reset_in_n |->
    !primary_outputs_oe && !primary_system_error_oe && !primary_grant_oe)
    else $error("primary enables on in reset");
  sec_rst_follow_a: assert property (!primary_reset_in_n
    |-> !secondary_reset_out_n) else $error("secondary reset off");
  sec_rst_soft_a: assert property (reg_wr && reg_addr == 8'h3c
    && reg_wdata[22] |-> ##[1:2] !secondary_reset_out_n)
    else $error("soft secondary reset missing");
  sec_rst_release_a: assert property ($rose(secondary_reset_out_n)
    |-> primary_reset_in_n && $past(primary_reset_in_n))
    else $error("secondary reset released early");
  ext_req_a: assert property ((arbiter_select_n && bridge_bus_req)[*3]
    |-> !secondary_grant_zero_n) else $error("external request missing");
  ext_gnt_a: assert property ((arbiter_select_n
    && !secondary_request_zero_n)[*3] |-> ext_arb_granted)
    else $error("external grant not seen");
  int_gnt_a: assert property ((!arbiter_select_n && !int_arb_gnt0_n)[*3]
    |-> !secondary_grant_zero_n) else $error("internal grant not routed");
  strap_status_a: assert property (reg_rd && reg_addr == 8'h1c |=>
    reg_rdata[21] == $past(primary_66mhz_strap))
    else $error("strap not in status");
  b2_entry_a: assert property ((reg_wr && reg_addr == 8'h44
    && reg_wdata[1:0] == 2'h3 && bus_power_clock_ctl_pin)
    ##1 (bus_power_clock_ctl_pin && primary_reset_in_n)[*2]
    |-> secondary_bus_b2) else $error("bus not in B2");
  gpio_dir_a: assert property ((reg_wr && reg_addr == 8'h48
    && secondary_reset_out_n) ##1 !reg_wr[*2]
    |-> gpio_oe == $past(reg_wdata[3:0], 2)) else $error("gpio oe wrong");
endmodule // brsc_checker

bind brsc_ctrl brsc_checker i_chk (.mclk, .reset_n, .primary_reset_in_n,
  .primary_system_error_oe, .primary_grant_oe, .primary_outputs_oe,
  .secondary_reset_out_n, .arbiter_select_n, .int_arb_gnt0_n,
  .bridge_bus_req, .secondary_request_zero_n, .secondary_grant_zero_n,
  .ext_arb_granted, .primary_66mhz_strap, .bus_power_clock_ctl_pin,
  .secondary_bus_b2, .gpio_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata);

// ===== brsc_ctrl.v
/*
  Reset distribution and strap control for a two-port bridge: primary output
  enables, secondary reset, arbiter routing, strap status, power state, GPIO
  direction, clock-disable capture and the serial memory port.
  Assumes inputs synchronous to mclk and a one-cycle read latency master.
*/
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "brsc_regs.vh"
module brsc_ctrl (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // Primary side
  input  wire        primary_reset_in_n,
  input  wire        pri_err_req,
  input  wire        pri_gnt_req,
  output reg         primary_system_error_n,
  output reg         primary_system_error_oe,
  output reg         primary_grant_n,
  output reg         primary_grant_oe,
  output reg         primary_outputs_oe,
  // Secondary reset and arbitration
  output reg         secondary_reset_out_n,
  input  wire        arbiter_select_n,
  input  wire        int_arb_gnt0_n,
  input  wire        bridge_bus_req,
  input  wire        secondary_request_zero_n,
  output reg         secondary_grant_zero_n,
  output reg         ext_arb_granted,
  // Straps and power
  input  wire        primary_66mhz_strap,
  input  wire        bus_power_clock_ctl_pin,
  output reg         secondary_bus_b2,
  // GPIO pins
  input  wire [3:0]  gpio_in,
  output reg  [3:0]  gpio_out,
  output reg  [3:0]  gpio_oe,
  output reg  [9:0]  sec_clk_disable,
  // Serial configuration memory
  input  wire        cfg_memory_enable_n,
  output reg         cfg_memory_serial_clock,
  input  wire        cfg_memory_serial_data_in,
  output reg         cfg_memory_serial_data_out,
  output reg         cfg_memory_serial_data_oe,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata
);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // Primary reset acts as a second async clear so header state cannot
  // outlive it even without a clock edge.
  wire       hdr_rst_n = reset_n & primary_reset_in_n;
  reg [31:0] bridge_ctl_reg;
  reg [1:0]  pm_state_reg;
  reg [3:0]  gpio_oe_reg;
  reg [3:0]  gpio_out_reg;
  reg [31:0] vpd_reg;
  reg        vpd_go_reg;
  wire       vpd_busy;
  wire       sclk_fall;
  wire [31:0] vpd_shift;

  always @(posedge mclk or negedge hdr_rst_n) begin
    if (!hdr_rst_n) begin
      bridge_ctl_reg <= `BRSC_BRIDGE_CTL_RST;
      pm_state_reg   <= 2'h0;
      gpio_oe_reg    <= `BRSC_GPIO_OE_RST;
      gpio_out_reg   <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `BRSC_BRIDGE_CTL: bridge_ctl_reg <= reg_wdata;
        `BRSC_PM_CTL:     pm_state_reg   <= reg_wdata[1:0];
        `BRSC_GPIO_OE:    gpio_oe_reg    <= reg_wdata[3:0];
        `BRSC_GPIO_OUT:   gpio_out_reg   <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // VPD data and go bit; go clears itself once the engine takes it.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vpd_reg    <= 32'h0000_0000;
      vpd_go_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `BRSC_VPD_CTL) begin
      vpd_reg    <= reg_wdata;
      vpd_go_reg <= reg_wdata[`BRSC_VPD_GO_BIT];
    end else begin
      if (vpd_busy)
        vpd_go_reg <= 1'b0;
      // The shift register moves on this same edge, so mirror its new value.
      if (vpd_busy && sclk_fall)
        vpd_reg[29:0] <= {vpd_shift[28:0], cfg_memory_serial_data_in};
    end
  end

  // ==========================================================================
  // Primary pins and secondary reset
  // ==========================================================================
  always @(posedge mclk or negedge hdr_rst_n) begin
    if (!hdr_rst_n) begin
      primary_outputs_oe      <= 1'b0;
      primary_system_error_oe <= 1'b0;
      primary_system_error_n  <= 1'b1;
      primary_grant_oe        <= 1'b0;
      primary_grant_n         <= 1'b1;
    end else begin
      primary_outputs_oe      <= 1'b1;
      primary_system_error_n  <= ~pri_err_req;
      primary_system_error_oe <= pri_err_req;
      primary_grant_n         <= ~pri_gnt_req;
      primary_grant_oe        <= 1'b1;
    end
  end

  wire sec_rst_bit = bridge_ctl_reg[`BRSC_SEC_RST_BIT];

  always @(posedge mclk or negedge hdr_rst_n) begin
    if (!hdr_rst_n)
      secondary_reset_out_n <= 1'b0;
    else
      secondary_reset_out_n <= ~sec_rst_bit;
  end

  // ==========================================================================
  // Secondary arbitration routing
  // ==========================================================================
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_grant_zero_n <= 1'b1;
      ext_arb_granted        <= 1'b0;
    end else if (arbiter_select_n) begin
      secondary_grant_zero_n <= ~bridge_bus_req;
      ext_arb_granted        <= ~secondary_request_zero_n;
    end else begin
      secondary_grant_zero_n <= int_arb_gnt0_n;
      ext_arb_granted        <= 1'b0;
    end
  end

  // ==========================================================================
  // Power state
  // ==========================================================================
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      secondary_bus_b2 <= 1'b0;
    else
      secondary_bus_b2 <= bus_power_clock_ctl_pin &&
                          pm_state_reg == `BRSC_PM_D3HOT;
  end

  // ==========================================================================
  // GPIO and clock-disable capture
  // ==========================================================================
  reg  pri_rst_seen_reg;
  wire mask_start = primary_reset_in_n && !secondary_reset_out_n;
  wire [9:0] mask_bits;
  wire       mask_done;

  brsc_shift_in #(
    .WIDTH (`BRSC_CLK_DIS_BITS)
  ) u_mask (
    .mclk     (mclk),
    .reset_n  (hdr_rst_n),
    .start    (mask_start & pri_rst_seen_reg),
    .bit_in   (gpio_in[0]),
    .data_reg (mask_bits),
    .done_reg (mask_done)
  );

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pri_rst_seen_reg <= 1'b1;
      gpio_out         <= 4'h0;
      gpio_oe          <= 4'h0;
      sec_clk_disable  <= `BRSC_CLK_DIS_RST;
    end else begin
      // Last primary reset level: the capture starts only on its release.
      pri_rst_seen_reg <= ~primary_reset_in_n;
      // GPIO pins stay inputs until the stream is in.
      gpio_oe          <= mask_done ? gpio_oe_reg : 4'h0;
      gpio_out         <= gpio_out_reg;
      sec_clk_disable  <= mask_done ? mask_bits : `BRSC_CLK_DIS_RST;
    end
  end

  // ==========================================================================
  // Serial configuration memory
  // ==========================================================================
  // A shift engine clocks 32 bits for autoload after reset and for each VPD
  // request. A transfer starts only while its enable input is low.
  reg [4:0]  bit_cnt_reg;
  reg [5:0]  half_cnt_reg;
  reg        busy_reg;
  reg        autoload_done_reg;
  reg        is_write_reg;
  reg [31:0] shreg_reg;
  localparam [31:0] SCLK_RELOAD = `BRSC_SCLK_HALF_CYC - 1;
  assign sclk_fall = busy_reg && half_cnt_reg == 6'h00 &&
                     cfg_memory_serial_clock;
  wire       mem_ok = ~cfg_memory_enable_n;
  assign vpd_busy  = busy_reg;
  assign vpd_shift = shreg_reg;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_reg               <= 5'h00;
      half_cnt_reg              <= 6'h00;
      busy_reg                  <= 1'b0;
      autoload_done_reg         <= 1'b0;
      is_write_reg              <= 1'b0;
      shreg_reg                 <= 32'h0000_0000;
      cfg_memory_serial_clock   <= 1'b0;
      cfg_memory_serial_data_out <= 1'b0;
      cfg_memory_serial_data_oe <= 1'b0;
    end else if (!busy_reg) begin
      cfg_memory_serial_clock   <= 1'b0;
      cfg_memory_serial_data_oe <= 1'b0;
      if (mem_ok && primary_reset_in_n &&
          (!autoload_done_reg || vpd_go_reg)) begin
        busy_reg          <= 1'b1;
        autoload_done_reg <= 1'b1;
        is_write_reg      <= vpd_go_reg && vpd_reg[`BRSC_VPD_WR_BIT];
        shreg_reg         <= vpd_reg;
        bit_cnt_reg       <= 5'h00;
        half_cnt_reg      <= 6'h00;
      end
    end else if (half_cnt_reg != 6'h00) begin
      half_cnt_reg <= half_cnt_reg - 6'h01;
    end else begin
      half_cnt_reg            <= SCLK_RELOAD[5:0];
      cfg_memory_serial_clock <= ~cfg_memory_serial_clock;
      if (!cfg_memory_serial_clock) begin
        cfg_memory_serial_data_out <= shreg_reg[31];
        cfg_memory_serial_data_oe  <= is_write_reg;
      end else begin
        shreg_reg   <= {shreg_reg[30:0], cfg_memory_serial_data_in};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == `BRSC_AUTOLOAD_BITS - 1)
          busy_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd) begin
      case (reg_addr)
        `BRSC_SEC_STATUS:
          reg_rdata <= {10'h000, primary_66mhz_strap, 21'h000000};
        `BRSC_BRIDGE_CTL: reg_rdata <= bridge_ctl_reg;
        `BRSC_PM_CTL:     reg_rdata <= {30'h0, pm_state_reg};
        `BRSC_GPIO_OE:    reg_rdata <= {28'h0, gpio_oe_reg};
        `BRSC_GPIO_OUT:   reg_rdata <= {28'h0, gpio_out_reg};
        `BRSC_GPIO_IN:    reg_rdata <= {28'h0, gpio_in};
        `BRSC_CLK_DIS:    reg_rdata <= {21'h0, mask_done, mask_bits};
        `BRSC_VPD_CTL:    reg_rdata <= {busy_reg, vpd_reg[30:0]};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else
      reg_rdata <= 32'h0000_0000;
  end
endmodule // brsc_ctrl

// ===== brsc_ctrl_tb.sv
/* Testbench for brsc_ctrl: register tasks and directed sequences.
   Assumes brsc_regs.vh, the checker bind and brsc_far_end. */
`timescale 1ns/10ps
`include "brsc_regs.vh"
// ========================================
// Testbench
module brsc_ctrl_tb;
  reg mclk, reset_n, primary_reset_in_n, pri_err_req, pri_gnt_req;
  reg arbiter_select_n, int_arb_gnt0_n, bridge_bus_req, strap, bpcc;
  reg [3:0] gpio_in;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata;
  reg reg_wr, reg_rd;
  wire [31:0] reg_rdata;
  wire [9:0] sec_clk_disable;
  wire [3:0] gpio_out, gpio_oe;
  wire se_n, se_oe, gn_n, gn_oe, pri_oe, sec_rst_n, gnt0_n, req0_n, granted;
  wire b2, mclk_sc, md_in, md_out, md_oe, men_n;
  integer mismatches, checks, cyc, i, sclk_rises, oe_rises;
  reg [31:0] d;
  brsc_ctrl i_dut (.mclk(mclk), .reset_n(reset_n),
    .primary_reset_in_n(primary_reset_in_n), .pri_err_req(pri_err_req),
    .pri_gnt_req(pri_gnt_req), .primary_system_error_n(se_n),
    .primary_system_error_oe(se_oe), .primary_grant_n(gn_n),
    .primary_grant_oe(gn_oe), .primary_outputs_oe(pri_oe),
    .secondary_reset_out_n(sec_rst_n), .arbiter_select_n(arbiter_select_n),
    .int_arb_gnt0_n(int_arb_gnt0_n), .bridge_bus_req(bridge_bus_req),
    .secondary_request_zero_n(req0_n), .secondary_grant_zero_n(gnt0_n),
    .ext_arb_granted(granted), .primary_66mhz_strap(strap),
    .bus_power_clock_ctl_pin(bpcc), .secondary_bus_b2(b2),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .sec_clk_disable(sec_clk_disable), .cfg_memory_enable_n(men_n),
    .cfg_memory_serial_clock(mclk_sc), .cfg_memory_serial_data_in(md_in),
    .cfg_memory_serial_data_out(md_out), .cfg_memory_serial_data_oe(md_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  brsc_far_end i_far (.mclk(mclk), .reset_n(reset_n),
    .arbiter_select_n(arbiter_select_n), .secondary_grant_zero_n(gnt0_n),
    .secondary_request_zero_n(req0_n), .cfg_memory_serial_data_out(md_out),
    .cfg_memory_serial_data_oe(md_oe), .cfg_memory_serial_data_in(md_in),
    .cfg_memory_enable_n(men_n));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Serial memory activity seen at the pins.
  always @(posedge mclk_sc) sclk_rises = sclk_rises + 1;
  always @(posedge md_oe) oe_rises = oe_rises + 1;
  task cmp(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %0s exp %h got %h", name, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd(input [7:0] a, output [31:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task tally_and_finish;
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk) cyc = cyc + 1;
      if (cyc > 10000) begin
        mismatches = mismatches + 1;
        tally_and_finish;
      end
    end
  end
  initial begin
    mismatches = 0; checks = 0;
    sclk_rises = 0; oe_rises = 0;
    reset_n = 0; primary_reset_in_n = 0; pri_err_req = 1; pri_gnt_req = 1;
    arbiter_select_n = 0; int_arb_gnt0_n = 1; bridge_bus_req = 0;
    strap = 1; bpcc = 0; gpio_in = 4'hf; reg_addr = 0; reg_wdata = 0;
    reg_wr = 0; reg_rd = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 cmp("pri_pins", 32'h3, {se_oe, gn_oe, pri_oe, se_n, gn_n});
    cmp("sec_rst_n", 32'h0, sec_rst_n);
    @(posedge mclk) primary_reset_in_n <= 1'b1;
    repeat (20) @(posedge mclk);
    #1 cmp("clk_dis", 32'h3ff, sec_clk_disable);
    cmp("sec_rst_n", 32'h1, sec_rst_n);
    cmp("pri_pins", 32'h1c, {se_oe, gn_oe, pri_oe, se_n, gn_n});
    rd(`BRSC_CLK_DIS, d);
    cmp("clk_dis_reg", 32'h7ff, d[10:0]);
    @(posedge mclk) gpio_in <= 4'h6;
    wr(`BRSC_GPIO_OUT, 32'ha);
    wr(`BRSC_GPIO_OE, 32'h5);
    repeat (3) @(posedge mclk);
    #1 cmp("gpio_oe", 32'h5, gpio_oe);
    cmp("gpio_out", 32'ha, gpio_out);
    rd(`BRSC_GPIO_IN, d);
    cmp("gpio_in", 32'h6, d[3:0]);
    rd(`BRSC_SEC_STATUS, d);
    cmp("strap_hi", 32'h1, d[21]);
    @(posedge mclk) strap <= 1'b0;
    rd(`BRSC_SEC_STATUS, d);
    cmp("strap_lo", 32'h0, d[21]);
    wr(`BRSC_BRIDGE_CTL, 32'h0040_0000);
    rd(`BRSC_BRIDGE_CTL, d);
    cmp("bridge_ctl", 32'h0040_0000, d);
    cmp("sec_rst_n", 32'h0, sec_rst_n);
    @(posedge mclk) primary_reset_in_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 cmp("pri_oe", 32'h0, {se_oe, gn_oe, pri_oe});
    @(posedge mclk) primary_reset_in_n <= 1'b1;
    repeat (20) @(posedge mclk);
    rd(`BRSC_BRIDGE_CTL, d);
    cmp("bridge_ctl", `BRSC_BRIDGE_CTL_RST, d);
    cmp("sec_rst_n", 32'h1, sec_rst_n);
    cmp("clk_dis", 32'h0, sec_clk_disable);
    rd(8'h80, d);
    cmp("unmapped", 32'h0, d);
    @(posedge mclk) bridge_bus_req <= 1'b1;
    arbiter_select_n <= 1'b1;
    for (i = 0; i < 20 && granted !== 1'b1; i = i + 1) begin
      @(posedge mclk);
      #1;
    end
    cmp("ext_gnt", 32'h1, granted);
    cmp("ext_req_n", 32'h0, gnt0_n);
    @(posedge mclk) bridge_bus_req <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 cmp("ext_gnt", 32'h0, granted);
    @(posedge mclk) arbiter_select_n <= 1'b0;
    int_arb_gnt0_n <= 1'b0;
    repeat (4) @(posedge mclk);
    #1 cmp("int_gnt0_n", 32'h0, gnt0_n);
    @(posedge mclk) int_arb_gnt0_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 cmp("int_gnt0_n", 32'h1, gnt0_n);
    @(posedge mclk) bpcc <= 1'b1;
    wr(`BRSC_PM_CTL, 32'h3);
    repeat (3) @(posedge mclk);
    #1 cmp("b2", 32'h1, b2);
    wr(`BRSC_PM_CTL, 32'h0);
    repeat (3) @(posedge mclk);
    #1 cmp("b2", 32'h0, b2);
    d = 32'h8000_0000;
    for (i = 0; i < 2000 && d[31]; i = i + 1) rd(`BRSC_VPD_CTL, d);
    cmp("vpd_busy", 32'h0, d[31]);
    cmp("sclk_rises", 32'h20, sclk_rises);
    cmp("oe_rises", 32'h0, oe_rises);
    wr(`BRSC_VPD_CTL, 32'hc000_00a5);
    d = 32'h8000_0000;
    for (i = 0; i < 2000 && d[31]; i = i + 1) rd(`BRSC_VPD_CTL, d);
    cmp("vpd_data", 32'h4000_00a5, d);
    cmp("sclk_rises", 32'h40, sclk_rises);
    cmp("oe_rises", 32'h1, oe_rises);
    tally_and_finish;
  end
endmodule // brsc_ctrl_tb

// ===== brsc_far_end.sv
/* Far side model: external secondary arbiter, board strap for the serial
   memory and the released serial data line.
   Assumes mclk is the only clock. */
`timescale 1ns/10ps
// ========================================
// Far end
module brsc_far_end #(
  parameter GNT_DLY = 2
) (
  input  wire mclk,
  input  wire reset_n,
  input  wire arbiter_select_n,
  input  wire secondary_grant_zero_n,
  output reg  secondary_request_zero_n,
  input  wire cfg_memory_serial_data_out,
  input  wire cfg_memory_serial_data_oe,
  output wire cfg_memory_serial_data_in,
  output wire cfg_memory_enable_n
);
  integer wait_cnt;
  reg     toggle_reg;
  // The board enables the serial memory, so autoload and VPD both run.
  assign cfg_memory_enable_n = 1'b0;
  // An undriven line has no pull, so it shows a changing pattern.
  assign cfg_memory_serial_data_in = cfg_memory_serial_data_oe ?
    cfg_memory_serial_data_out : toggle_reg;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      secondary_request_zero_n <= 1'b1;
      wait_cnt                 <= 0;
      toggle_reg               <= 1'b0;
    end else begin
      toggle_reg <= ~toggle_reg;
      if (arbiter_select_n && !secondary_grant_zero_n) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= GNT_DLY)
          secondary_request_zero_n <= 1'b0;
      end else begin
        wait_cnt                 <= 0;
        secondary_request_zero_n <= 1'b1;
      end
    end
  end
endmodule // brsc_far_end

// ===== brsc_regs.vh
/*
  Constants for the bridge reset and strap control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a single 40 MHz clock and the plain register port of the top module.
*/
// Summary of operation
// - Primary reset asynchronously turns off all primary output enables, error and grant.
// - Primary reset returns standard header registers 0h-3Fh to defaults.
// - Secondary reset output asserts whenever primary reset is asserted.
// - Secondary reset output also asserts while the software secondary-reset bit is set.
// - Arbiter select low picks internal arbiter, high picks external arbiter.
// - External mode: request zero is grant in, grant zero is request out.
// - The 66 MHz strap level shows in secondary status; nothing else uses it.
// - Power pin high plus D3hot places the secondary bus in B2.
// - Each of four GPIO pins is input-only or driven per output-enable register.
// - During reset the GPIO pins shift in secondary clock-disable serial data; the code shifts in gpio_in[0] only, after primary reset ends.
// - Device drives memory serial clock during autoload and VPD, data pin two-way.
// - Clock-disable stream starts once primary reset is off, secondary reset still on.
`ifndef BRSC_REGS_VH
`define BRSC_REGS_VH

// Standard header offsets (byte addresses of the primary port).
`define BRSC_HDR_LAST        8'h3f
`define BRSC_SEC_STATUS      8'h1c
`define BRSC_BRIDGE_CTL      8'h3c
// Block-local control registers.
`define BRSC_PM_CTL          8'h44
`define BRSC_GPIO_OE         8'h48
`define BRSC_GPIO_OUT        8'h4c
`define BRSC_GPIO_IN         8'h50
`define BRSC_CLK_DIS         8'h54
`define BRSC_VPD_CTL         8'h58
// Field positions.
`define BRSC_SEC_RST_BIT     22
`define BRSC_M66_BIT         21
`define BRSC_PM_STATE_LSB    0
`define BRSC_PM_D3HOT        2'h3
`define BRSC_VPD_GO_BIT      31
`define BRSC_VPD_WR_BIT      30
// Reset values.
`define BRSC_BRIDGE_CTL_RST  32'h0000_0000
`define BRSC_GPIO_OE_RST     4'h0
`define BRSC_CLK_DIS_RST     10'h000
// Timing: serial memory clock half period, and the clock-disable length.
`define BRSC_SCLK_HALF_NS    1250
`define BRSC_CLK_NS          25
`define BRSC_SCLK_HALF_CYC   (`BRSC_SCLK_HALF_NS / `BRSC_CLK_NS)
`define BRSC_CLK_DIS_BITS    10
`define BRSC_AUTOLOAD_BITS   32

`endif

// ===== brsc_shift_in.v
/*
  Serial shift register for the secondary clock-disable stream.
  Assumes the serial source is synchronous to mclk; bits enter LSB first.
*/
`timescale 1ns/10ps
module brsc_shift_in #(
  parameter WIDTH = 10
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset_n,
  // Control
  input  wire             start,
  input  wire             bit_in,
  // Result
  output reg  [WIDTH-1:0] data_reg,
  output reg              done_reg
);
  reg [4:0] count_reg;
  reg       run_reg;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg  <= {WIDTH{1'b0}};
      done_reg  <= 1'b0;
      count_reg <= 5'h00;
      run_reg   <= 1'b0;
    end else if (start && !run_reg && !done_reg) begin
      run_reg   <= 1'b1;
      count_reg <= 5'h00;
    end else if (run_reg) begin
      data_reg  <= {bit_in, data_reg[WIDTH-1:1]};
      count_reg <= count_reg + 5'h01;
      if (count_reg == WIDTH - 1) begin
        run_reg  <= 1'b0;
        done_reg <= 1'b1;
      end
    end
  end
endmodule // brsc_shift_in
